// ---- dv/host_trigger_model.sv ----
// host side model: trigger pulses on the error trigger pin
`timescale 1ns/10ps
`default_nettype none
module host_trigger_model (
   input  wire logic       mclk_in,  // clock
   input  wire logic       reset_in, // sync reset
   input  wire logic       fire_in,  // start one pulse
   input  wire logic [7:0] hold_in,  // high time in cycles
   output logic            trig_out  // trigger pin level
);
   logic [7:0] left;
   // pin idles low; monitor function never used here
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         left     <= 8'h00;
         trig_out <= 1'b0;
      end else if (fire_in) begin
         left     <= hold_in;
         trig_out <= 1'b1;
      end else if (left > 8'h01) begin
         left <= left - 8'h01;
      end else begin
         left     <= 8'h00;
         trig_out <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- dv/wd_props.sv ----
// port-level assertion checker for the window watchdog
`timescale 1ns/10ps
`default_nettype none
module wd_props
   import wd_pkg::*;
#(
   parameter int STEP_CNT  = 10,
   parameter int PULSE_CNT = 4
) (
   input wire logic       mclk_in,          // clock
   input wire logic       reset_in,         // sync reset
   input wire logic [3:0] reg_addr_in,      // address
   input wire logic [7:0] reg_wdata_in,     // write data
   input wire logic       reg_wr_in,        // write strobe
   input wire logic       reg_rd_in,        // read strobe
   input wire logic [7:0] reg_rdata_out,    // read data
   input wire logic       error_trigger_in, // trigger pin
   input wire logic       spi_frame_in,     // spi frame
   input wire logic       enable_drive_out, // drive enable
   input wire logic       mcu_reset_out     // mcu reset
);
   // ==========================================================
   // control shadow, delayed once to match the output lag
   logic [1:0] ctrl_now;
   logic [1:0] ctrl_seen;
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         ctrl_now <= 2'h0;
      end else if (reg_wr_in && reg_addr_in == OFF_CHECK_CTRL) begin
         ctrl_now <= {reg_wdata_in[BIT_OTHER_ERR], reg_wdata_in[BIT_DRIVE_REQ]};
      end
   end
   always_ff @(posedge mclk_in) begin
      ctrl_seen <= ctrl_now;
   end
   // ==========================================================
   // assertions
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (reset_in);
   a_drive_needs_req: assert property (
      enable_drive_out |-> ctrl_seen == 2'b01) else $error("drive without request");
   a_range_drive_low: assert property (
      $past(reg_rd_in) && $past(reg_addr_in) == OFF_FAIL_CNT && reg_rdata_out >= 8'h05
      |-> !enable_drive_out) else $error("drive high with count out of range");
   a_cfg_write_counts: assert property (
      reg_wr_in && (reg_addr_in == OFF_CLOSE_CFG || reg_addr_in == OFF_OPEN_CFG)
      ##1 reg_rd_in && reg_addr_in == OFF_FAIL_CNT
      |=> reg_rdata_out != 8'h00) else $error("window write left fail count at zero");
   a_status_range: assert property (
      $past(reg_rd_in) && $past(reg_addr_in) == OFF_STATUS && reg_rdata_out[BIT_OUT_RANGE]
      |-> !enable_drive_out) else $error("drive high while out of range");
   a_trip_drive_low: assert property (
      $fell(mcu_reset_out) |-> !enable_drive_out [*8]) else $error("drive after trip");
   a_trip_short: assert property (
      $fell(mcu_reset_out) |-> ##[1:4] mcu_reset_out) else $error("reset pulse too long");
   a_reset_drive_low: assert property (
      !mcu_reset_out |-> !enable_drive_out) else $error("drive during mcu reset");
   a_release_mcu: assert property (
      $fell(reset_in) |-> ##[0:3] mcu_reset_out) else $error("mcu reset stuck low");
   c_trip: cover property ($fell(mcu_reset_out));
   c_drive: cover property ($rose(enable_drive_out));
   c_token: cover property (reg_rd_in && reg_addr_in == OFF_QA_TOKEN);
endmodule
`default_nettype wire

// ---- dv/window_watchdog_fail_counter_tb_top.sv ----
// self-checking bench for the window watchdog fail counter
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
   $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module window_watchdog_fail_counter_tb_top;
   import wd_pkg::*;
   typedef struct {logic [3:0] a; logic [7:0] e;} row_t;
   logic       mclk_in = 1'b0;
   logic       reset_in = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic       fire = 1'b0;
   logic       spi_frame = 1'b0;
   logic [7:0] rdata;
   logic [7:0] v;
   logic [3:0] tok;
   logic       trig;
   logic       drive;
   logic       mcu_rst;
   int         failures = 0;
   int         n_tests = 0;
   int         cyc = 0;
   row_t rows[8] = '{'{OFF_SAFETY_CFG, 8'h00}, '{OFF_CHECK_CTRL, 8'h00},
      '{OFF_CLOSE_CFG, 8'h08}, '{OFF_OPEN_CFG, 8'h08}, '{OFF_STATUS, 8'h04},
      '{OFF_FAIL_CNT, 8'h05}, '{OFF_DEV_STATE, 8'h01}, '{4'hf, 8'h00}};
   window_watchdog_fail_counter #(.STEP_CNT(10), .PULSE_CNT(4)) window_watchdog_fail_counter_i (
      .mclk_in, .reset_in, .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
      .reg_rd_in(rd), .reg_rdata_out(rdata), .error_trigger_in(trig),
      .spi_frame_in(spi_frame), .enable_drive_out(drive), .mcu_reset_out(mcu_rst));
   host_trigger_model host_trigger_model_i (
      .mclk_in, .reset_in, .fire_in(fire), .hold_in(8'h06), .trig_out(trig));
   initial begin
      forever #50 mclk_in = ~mclk_in;
   end
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         end_of_test;
      end
   end
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk_in);
      wr <= 1'b0;
   endtask
   task automatic chk_rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge mclk_in);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk_in);
      rd <= 1'b0;
      #1 v = rdata;
      `CHK(v, e)
   endtask
   // event lands about eight cycles after w + 1 edges
   task automatic pulse(input int w);
      repeat (w + 1) @(posedge mclk_in);
      fire <= 1'b1;
      @(posedge mclk_in);
      fire <= 1'b0;
      repeat (8) @(posedge mclk_in);
   endtask
   task automatic drive_is(input logic e);
      repeat (3) @(posedge mclk_in);
      #1 `CHK(drive, e)
   endtask
   task automatic wait_trip;
      int k;
      // look after the edge's updates have settled
      #1 k = 0;
      while (mcu_rst !== 1'b0 && k < 10) begin
         @(posedge mclk_in);
         #1 k++;
      end
      `CHK(mcu_rst, 1'b0)
      repeat (6) @(posedge mclk_in);
   endtask
   initial begin
      repeat (20) @(posedge mclk_in);
      reset_in <= 1'b0;
      repeat (3) @(posedge mclk_in);
      #1 `CHK(mcu_rst, 1'b1)
      foreach (rows[i]) chk_rd(rows[i].a, rows[i].e);
      wr_reg(OFF_CLOSE_CFG, 8'h02);
      wr_reg(OFF_OPEN_CFG, 8'h03);
      chk_rd(OFF_FAIL_CNT, 8'h07);
      wr_reg(OFF_OPEN_CFG, 8'h03);
      chk_rd(OFF_FAIL_CNT, 8'h07);
      repeat (3) pulse(20);
      chk_rd(OFF_FAIL_CNT, 8'h04);
      wr_reg(OFF_CHECK_CTRL, 8'h01);
      drive_is(1'b1);
      wr_reg(OFF_CHECK_CTRL, 8'h03);
      drive_is(1'b0);
      wr_reg(OFF_CHECK_CTRL, 8'h01);
      pulse(10);
      pulse(0);
      drive_is(1'b1);
      chk_rd(OFF_STATUS, 8'h01);
      pulse(0);
      drive_is(1'b0);
      chk_rd(OFF_STATUS, 8'h05);
      repeat (60) @(posedge mclk_in);
      chk_rd(OFF_STATUS, 8'h06);
      chk_rd(OFF_FAIL_CNT, 8'h06);
      wr_reg(OFF_CLOSE_CFG, 8'h02);
      wr_reg(OFF_SAFETY_CFG, 8'h08);
      wait_trip;
      chk_rd(OFF_FAIL_CNT, 8'h05);
      chk_rd(OFF_DEV_STATE, 8'h01);
      wr_reg(OFF_SAFETY_CFG, 8'h28);
      chk_rd(OFF_SAFETY_CFG, 8'h28);
      repeat (2) wr_reg(OFF_CLOSE_CFG, 8'h02);
      // reaching seven with reset enabled must not trip by itself
      #1 `CHK(mcu_rst, 1'b1)
      wr_reg(OFF_CLOSE_CFG, 8'h02);
      wait_trip;
      chk_rd(OFF_SAFETY_CFG, 8'h00);
      chk_rd(OFF_CLOSE_CFG, 8'h08);
      wr_reg(OFF_SAFETY_CFG, 8'h20);
      wr_reg(OFF_OPEN_CFG, 8'h08);
      wr_reg(OFF_DEV_STATE, 8'h01);
      chk_rd(OFF_FAIL_CNT, 8'h05);
      wr_reg(OFF_CLOSE_CFG, 8'h05);
      chk_rd(OFF_CLOSE_CFG, 8'h08);
      wr_reg(OFF_SAFETY_CFG, 8'h00);
      chk_rd(OFF_SAFETY_CFG, 8'h20);
      chk_rd(OFF_QA_TOKEN, {4'h0, TOKEN_INIT});
      tok = TOKEN_INIT;
      repeat (85) @(posedge mclk_in);
      for (logic [3:0] j = 4'h0; j < 4'h4; j++) wr_reg(OFF_QA_ANSWER, {tok ^ j, ~tok});
      chk_rd(OFF_FAIL_CNT, 8'h05);
      chk_rd(OFF_QA_TOKEN, {4'h0, TOKEN_INIT + 4'h1});
      wr_reg(OFF_QA_ANSWER, {tok, tok});
      chk_rd(OFF_FAIL_CNT, 8'h06);
      // time-out inside a host frame still counts but leaves the flag clear
      spi_frame <= 1'b1;
      repeat (175) @(posedge mclk_in);
      chk_rd(OFF_STATUS, 8'h0c);
      chk_rd(OFF_FAIL_CNT, 8'h07);
      end_of_test;
   end
endmodule
bind window_watchdog_fail_counter wd_props #(.STEP_CNT(STEP_CNT), .PULSE_CNT(PULSE_CNT)) wd_props_i (
   .mclk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
   .error_trigger_in, .spi_frame_in, .enable_drive_out, .mcu_reset_out);
`default_nettype wire

// ---- hdl/wd_pkg.sv ----
// constants and types for the window watchdog with fail counter
package wd_pkg;
   // ==========================================================
   // timing
   localparam int  CLK_HZ          = 10_000_000;
   localparam int  STEP_NS         = 550_000;
   localparam int  STEP_CYCLES     = (STEP_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam int  PULSE_US        = 32;
   localparam int  PULSE_CYCLES    = (PULSE_US * CLK_HZ) / 1_000_000 + 1;
   // ==========================================================
   // register offsets (4-bit address)
   localparam logic [3:0] OFF_SAFETY_CFG = 4'h0;
   localparam logic [3:0] OFF_CHECK_CTRL = 4'h1;
   localparam logic [3:0] OFF_CLOSE_CFG  = 4'h2;
   localparam logic [3:0] OFF_OPEN_CFG   = 4'h3;
   localparam logic [3:0] OFF_STATUS     = 4'h4;
   localparam logic [3:0] OFF_FAIL_CNT   = 4'h5;
   localparam logic [3:0] OFF_DEV_STATE  = 4'h6;
   localparam logic [3:0] OFF_QA_ANSWER  = 4'h7;
   localparam logic [3:0] OFF_QA_TOKEN   = 4'h8;
   // ==========================================================
   // field positions
   localparam int BIT_QA_MODE       = 5;
   localparam int BIT_FAIL_RST_EN   = 3;
   localparam int BIT_DRIVE_REQ     = 0;
   localparam int BIT_TIME_OUT      = 1;
   localparam int BIT_EARLY         = 0;
   localparam int BIT_OUT_RANGE     = 2;
   localparam int BIT_BAD_ANSWER    = 3;
   localparam int BIT_GO_ACTIVE     = 0;
   localparam int BIT_OTHER_ERR     = 1;
   // ==========================================================
   // reset values and fail counter limits
   localparam logic [6:0] CLOSE_DEFAULT = 7'h08;
   localparam logic [4:0] OPEN_DEFAULT  = 5'h08;
   localparam logic [2:0] FAIL_INIT     = 3'h5;
   localparam logic [2:0] FAIL_MAX      = 3'h7;
   localparam logic [2:0] FAIL_LIMIT    = 3'h5;
   localparam logic [3:0] TOKEN_INIT    = 4'h0;

   typedef enum {ST_RESET, ST_DIAG, ST_ACTIVE} dev_state_t;
   typedef enum {WIN_CLOSE, WIN_OPEN} window_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;
endpackage

// ---- hdl/window_watchdog_fail_counter.sv ----
// window watchdog with saturating fail counter, drive enable and mcu reset
// ==========================================================
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module window_watchdog_fail_counter
   import wd_pkg::*;
#(
   parameter int STEP_CNT  = STEP_CYCLES,
   parameter int PULSE_CNT = PULSE_CYCLES
) (
   input  wire logic       mclk_in,           // system clock, 10 MHz
   input  wire logic       reset_in,          // synchronous, active high
   input  wire logic [3:0] reg_addr_in,       // register address
   input  wire logic [7:0] reg_wdata_in,      // write data
   input  wire logic       reg_wr_in,         // write strobe
   input  wire logic       reg_rd_in,         // read strobe
   output logic      [7:0] reg_rdata_out,     // read data, cycle after strobe
   input  wire logic       error_trigger_in,  // trigger pulses from host
   input  wire logic       spi_frame_in,      // spi frame active
   output logic            enable_drive_out,  // power stage enable
   output logic            mcu_reset_out      // mcu reset, low active level
);
   import wd_pkg::*;

   reg_req_t   req;
   dev_state_t dev_state;
   window_t    window;
   logic [7:0] safety_function_config;
   logic       drive_enable_request;
   logic       other_error;
   logic [6:0] close_window_steps;
   logic [4:0] open_window_steps;
   logic [2:0] fail_count;
   logic [3:0] watchdog_status_reg;
   logic [3:0] qa_token;
   logic [1:0] qa_index;
   logic [31:0] step_timer;
   logic [7:0] steps_left;
   logic       step_tick;
   logic [31:0] pulse_timer;
   logic       trig_q;
   logic       trigger;
   logic       qa_byte_ok;
   logic       good_evt;
   logic       bad_evt;
   logic       timeout_evt;
   logic       cfg_win_wr;
   logic       seq_restart;
   logic       qa_mode_select;
   logic       fail_reset_enable;
   logic       fail_trip;
   logic       rst_en_rise;

   assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};
   assign qa_mode_select    = safety_function_config[BIT_QA_MODE];
   assign fail_reset_enable = safety_function_config[BIT_FAIL_RST_EN];

   function automatic logic [7:0] expected_answer(input logic [3:0] tok, input logic [1:0] idx);
      expected_answer = {tok ^ {2'h0, idx}, ~tok};
   endfunction

   // ==========================================================
   // trigger deglitch: high must last past the pulse time
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         trig_q      <= 1'b0;
         pulse_timer <= '0;
      end else begin
         trig_q <= error_trigger_in;
         if (!trig_q)
            pulse_timer <= '0;
         else if (pulse_timer < 32'(PULSE_CNT))
            pulse_timer <= pulse_timer + 32'h1;
      end
   end
   // falling edge after a long enough high
   assign trigger = !qa_mode_select && trig_q && !error_trigger_in
                    && pulse_timer >= 32'(PULSE_CNT);

   // ==========================================================
   // event classification
   assign cfg_win_wr = req.wr && (req.addr == OFF_CLOSE_CFG || req.addr == OFF_OPEN_CFG);
   assign qa_byte_ok = req.wdata == expected_answer(qa_token, qa_index);
   always_comb begin
      good_evt    = 1'b0;
      bad_evt     = 1'b0;
      timeout_evt = 1'b0;
      if (dev_state != ST_RESET) begin
         if (cfg_win_wr) begin
            bad_evt = 1'b1;
         end else if (qa_mode_select) begin
            if (req.wr && req.addr == OFF_QA_ANSWER) begin
               if (!qa_byte_ok || window == WIN_CLOSE)
                  bad_evt = 1'b1;
               else if (qa_index == 2'h3)
                  good_evt = 1'b1;
            end
         end else if (trigger) begin
            if (window == WIN_OPEN)
               good_evt = 1'b1;
            else
               bad_evt = 1'b1;
         end
         if (!good_evt && !bad_evt && window == WIN_OPEN && step_tick
             && steps_left == 8'h0)
            timeout_evt = 1'b1;
      end
   end
   assign seq_restart = good_evt || bad_evt || timeout_evt;
   // reaching seven is not a trip by itself: it needs a bad or time-out event with the enable set, or the enable being set
   assign rst_en_rise = req.wr && req.addr == OFF_SAFETY_CFG
                        && req.wdata[BIT_FAIL_RST_EN] && !fail_reset_enable;
   assign fail_trip = dev_state != ST_RESET && fail_count == FAIL_MAX
                      && ((fail_reset_enable && (bad_evt || timeout_evt))
                          || rst_en_rise);

   // ==========================================================
   // step timer and windows
   assign step_tick = step_timer == 32'(STEP_CNT - 1);
   always_ff @(posedge mclk_in) begin
      if (reset_in || dev_state == ST_RESET || seq_restart) begin
         step_timer <= '0;
         window     <= WIN_CLOSE;
         // step timer restarts with the sequence, so the first close step is a full step
         steps_left <= (close_window_steps == 7'h0) ? 8'h0
                       : {1'b0, close_window_steps} - 8'h1;
      end else if (step_tick) begin
         step_timer <= '0;
         if (steps_left != 8'h0)
            steps_left <= steps_left - 8'h1;
         else if (window == WIN_CLOSE) begin
            window     <= WIN_OPEN;
            steps_left <= {3'h0, open_window_steps};
         end
      end else begin
         step_timer <= step_timer + 32'h1;
      end
   end

   // ==========================================================
   // device state
   always_ff @(posedge mclk_in) begin
      if (reset_in)
         dev_state <= ST_RESET;
      else if (fail_trip && dev_state != ST_RESET)
         dev_state <= ST_RESET;
      else if (dev_state == ST_RESET)
         dev_state <= ST_DIAG;
      else if (dev_state == ST_DIAG && req.wr && req.addr == OFF_DEV_STATE
               && req.wdata[BIT_GO_ACTIVE])
         dev_state <= ST_ACTIVE;
   end

   // ==========================================================
   // fail counter, counts the same for either fail-reset setting
   always_ff @(posedge mclk_in) begin
      if (reset_in || dev_state == ST_RESET)
         fail_count <= FAIL_INIT;
      else if (dev_state == ST_DIAG && req.wr && req.addr == OFF_DEV_STATE
               && req.wdata[BIT_GO_ACTIVE])
         fail_count <= FAIL_INIT;
      else if ((bad_evt || timeout_evt) && fail_count != FAIL_MAX)
         fail_count <= fail_count + 3'h1;
      else if (good_evt && fail_count != 3'h0)
         fail_count <= fail_count - 3'h1;
   end

   // ==========================================================
   // configuration registers
   always_ff @(posedge mclk_in) begin
      if (reset_in || dev_state == ST_RESET) begin
         safety_function_config <= 8'h00;
         close_window_steps     <= CLOSE_DEFAULT;
         open_window_steps      <= OPEN_DEFAULT;
         drive_enable_request   <= 1'b0;
         other_error            <= 1'b0;
      end else if (req.wr) begin
         unique case (req.addr)
            OFF_SAFETY_CFG: begin
               safety_function_config[BIT_FAIL_RST_EN] <= req.wdata[BIT_FAIL_RST_EN];
               if (dev_state == ST_DIAG)
                  safety_function_config[BIT_QA_MODE] <= req.wdata[BIT_QA_MODE];
            end
            OFF_CHECK_CTRL: begin
               drive_enable_request <= req.wdata[BIT_DRIVE_REQ];
               other_error          <= req.wdata[BIT_OTHER_ERR];
            end
            OFF_CLOSE_CFG:
               if (dev_state == ST_DIAG)
                  close_window_steps <= req.wdata[6:0];
            OFF_OPEN_CFG:
               if (dev_state == ST_DIAG)
                  open_window_steps <= req.wdata[4:0];
            default: ;
         endcase
      end
   end

   // ==========================================================
   // status flags, set beats read-clear
   always_ff @(posedge mclk_in) begin
      if (reset_in || dev_state == ST_RESET) begin
         watchdog_status_reg <= 4'h0;
      end else begin
         if (req.rd && req.addr == OFF_STATUS)
            watchdog_status_reg <= 4'h0;
         if (timeout_evt && !spi_frame_in)
            watchdog_status_reg[BIT_TIME_OUT] <= 1'b1;
         if (bad_evt && trigger && window == WIN_CLOSE && !cfg_win_wr)
            watchdog_status_reg[BIT_EARLY] <= 1'b1;
         if (bad_evt && qa_mode_select && !cfg_win_wr)
            watchdog_status_reg[BIT_BAD_ANSWER] <= 1'b1;
      end
   end

   // ==========================================================
   // question-answer sequencing
   always_ff @(posedge mclk_in) begin
      if (reset_in || dev_state == ST_RESET) begin
         qa_token <= TOKEN_INIT;
         qa_index <= 2'h0;
      end else if (seq_restart) begin
         qa_index <= 2'h0;
         if (good_evt && qa_mode_select)
            qa_token <= qa_token + 4'h1;
      end else if (qa_mode_select && req.wr && req.addr == OFF_QA_ANSWER) begin
         qa_index <= qa_index + 2'h1;
      end
   end

   // ==========================================================
   // outputs and readback
   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         enable_drive_out <= 1'b0;
         mcu_reset_out    <= 1'b0;
      end else begin
         enable_drive_out <= drive_enable_request && !other_error
                             && fail_count < FAIL_LIMIT && dev_state != ST_RESET
                             && !fail_trip;
         mcu_reset_out    <= dev_state != ST_RESET && !fail_trip;
      end
   end

   always_ff @(posedge mclk_in) begin
      if (reset_in) begin
         reg_rdata_out <= 8'h00;
      end else if (req.rd) begin
         unique case (req.addr)
            OFF_SAFETY_CFG: reg_rdata_out <= safety_function_config;
            OFF_CHECK_CTRL: reg_rdata_out <= {6'h0, other_error, drive_enable_request};
            OFF_CLOSE_CFG:  reg_rdata_out <= {1'b0, close_window_steps};
            OFF_OPEN_CFG:   reg_rdata_out <= {3'h0, open_window_steps};
            OFF_STATUS:     reg_rdata_out <= {4'h0, watchdog_status_reg[3],
                                              fail_count >= FAIL_LIMIT,
                                              watchdog_status_reg[1:0]};
            OFF_FAIL_CNT:   reg_rdata_out <= {5'h0, fail_count};
            OFF_DEV_STATE:  reg_rdata_out <= {6'h0, dev_state == ST_ACTIVE,
                                              dev_state == ST_DIAG};
            OFF_QA_TOKEN:   reg_rdata_out <= {2'h0, qa_index, qa_token};
            default:        reg_rdata_out <= 8'h00;
         endcase
      end else begin
         reg_rdata_out <= 8'h00;
      end
   end
endmodule
`default_nettype wire
